// *** pkg/fault_sim_pkg.sv ***
// shared constants of the fault simulation sequencer
// assumes a 200 MHz system clock and one asynchronous active-low reset
package fault_sim_pkg;
    localparam int unsigned CLOCK_HZ = 200_000_000;
    localparam int unsigned RESET_PHASE_MS = 100;
    localparam int unsigned RESET_PHASE_CYCLES = RESET_PHASE_MS * (CLOCK_HZ / 1000);
    localparam int unsigned RESTART_HOLD_S = 5;
    localparam longint unsigned RESTART_HOLD_CYCLES = longint'(RESTART_HOLD_S) * CLOCK_HZ;
    // simulated frequency offset in units of 0.01 percent
    localparam int unsigned FREQ_OFFSET_CENTI_PCT = 16;
    localparam int unsigned FREQ_SCALE_DEN = 10000;
    localparam int unsigned PHASE_TIME_W = 32;
    localparam int unsigned FREQ_W = 32;
    localparam logic [2:0] CODE_NORMAL = 3'h0;
    localparam logic [2:0] CODE_PRE = 3'h1;
    localparam logic [2:0] CODE_FAULT = 3'h2;
    localparam logic [2:0] CODE_POST = 3'h3;
    localparam logic [2:0] CODE_RESET = 3'h4;
    localparam logic TRIP_SUPPRESS = 1'b0;
    localparam logic TRIP_PASS = 1'b1;
    typedef enum logic [5:0] {
        ST_NORMAL = 6'h01,
        ST_RESET_IN = 6'h02,
        ST_PRE = 6'h04,
        ST_FAULT = 6'h08,
        ST_POST = 6'h10,
        ST_RESET_OUT = 6'h20
    } seq_state_e;
endpackage : fault_sim_pkg

// *** hdl/input_sync.sv ***
// two-flop synchroniser bank for asynchronous level inputs
// assumes inputs are slow levels; no glitch filtering beyond the two flops
`timescale 1ns/1ps
module input_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;

    initial begin
        if (WIDTH < 1) $error("input_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage_one <= '0;
            stage_two <= '0;
        end else begin
            stage_one <= async_i;
            stage_two <= stage_one;
        end
    end

    assign sync_o = stage_two;
endmodule : input_sync

// *** hdl/fault_simulation_sequencer.sv ***
// fault simulation sequencer: reset, pre-fault, fault, post-fault, reset, back to normal
// assumes command and signal inputs are asynchronous levels; durations come from settings
`timescale 1ns/1ps
module fault_simulation_sequencer
    import fault_sim_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = fault_sim_pkg::RESET_PHASE_CYCLES,
    parameter longint unsigned HOLD_CYCLES = fault_sim_pkg::RESTART_HOLD_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic manual_start_i,
    input wire logic manual_stop_i,
    input wire logic external_start_input_i,
    input wire logic external_start_assigned_i,
    input wire logic external_block_one_i,
    input wire logic external_block_two_i,
    input wire logic force_post_fault_input_i,
    input wire logic force_post_assigned_i,
    input wire logic phase_overcurrent_i,
    input wire logic trip_pass_setting_i,
    input wire logic protection_trip_command_i,
    input wire logic [fault_sim_pkg::PHASE_TIME_W-1:0] pre_fault_cycles_i,
    input wire logic [fault_sim_pkg::PHASE_TIME_W-1:0] fault_cycles_i,
    input wire logic [fault_sim_pkg::PHASE_TIME_W-1:0] post_fault_cycles_i,
    input wire logic [fault_sim_pkg::FREQ_W-1:0] rated_freq_i,
    output logic [2:0] state_code_o,
    output logic protection_disable_o,
    output logic energy_counter_stop_o,
    output logic simulation_active_o,
    output logic voltage_phase_neutral_o,
    output logic [fault_sim_pkg::FREQ_W-1:0] sim_freq_o,
    output logic breaker_trip_o,
    output logic start_refused_o
);
    import fault_sim_pkg::*;

    initial begin
        if (RESET_CYCLES < 1) $error("RESET_CYCLES must be at least 1");
        if (HOLD_CYCLES < 1) $error("HOLD_CYCLES must be at least 1");
    end

    logic [5:0] async_in;
    logic [5:0] sync_in;
    assign async_in = {manual_start_i, manual_stop_i, external_start_input_i,
                       external_block_one_i | external_block_two_i,
                       force_post_fault_input_i, phase_overcurrent_i};

    input_sync #(.WIDTH(6)) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(async_in),
        .sync_o(sync_in)
    );

    logic start_lvl, stop_lvl, ext_lvl, blocked, force_lvl, overcurrent;
    assign {start_lvl, stop_lvl, ext_lvl, blocked, force_lvl, overcurrent} = sync_in;

    seq_state_e state, next_state;
    logic [PHASE_TIME_W-1:0] timer, next_timer;
    logic [63:0] hold, next_hold;
    logic lockout, next_lockout;
    logic start_prev, ext_prev;
    logic [2:0] next_code;
    logic start_req, force_edge, run;

    // starts are edge triggered so a held command does not restart a finished run
    assign start_req = (start_lvl & ~start_prev) |
                       (external_start_assigned_i & ext_lvl & ~ext_prev);
    // force acts on its level while assigned, so a force held high skips ahead on entry
    assign force_edge = force_post_assigned_i & force_lvl;
    assign run = (state != ST_NORMAL);

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_lockout = lockout;
        next_hold = hold;
        // lockout ends only after a continuous quiet stretch of current
        if (overcurrent) begin
            next_hold = '0;
        end else if (lockout) begin
            if (hold >= HOLD_CYCLES - 64'd1) begin
                next_lockout = 1'b0;
                next_hold = '0;
            end else begin
                next_hold = hold + 64'd1;
            end
        end
        case (state)
            ST_NORMAL: begin
                if (start_req && !blocked && !lockout && !overcurrent) begin
                    next_state = ST_RESET_IN;
                    next_timer = '0;
                end
            end
            ST_RESET_IN: begin
                next_timer = timer + 1'b1;
                if (timer >= PHASE_TIME_W'(RESET_CYCLES - 1)) begin
                    next_state = ST_PRE;
                    next_timer = '0;
                end
            end
            ST_PRE: begin
                next_timer = timer + 1'b1;
                if (force_edge) begin
                    next_state = ST_POST;
                    next_timer = '0;
                end else if (timer + 1'b1 >= pre_fault_cycles_i) begin
                    next_state = ST_FAULT;
                    next_timer = '0;
                end
            end
            ST_FAULT: begin
                next_timer = timer + 1'b1;
                if (force_edge) begin
                    next_state = ST_POST;
                    next_timer = '0;
                end else if (timer + 1'b1 >= fault_cycles_i) begin
                    next_state = ST_POST;
                    next_timer = '0;
                end
            end
            ST_POST: begin
                next_timer = timer + 1'b1;
                if (timer + 1'b1 >= post_fault_cycles_i) begin
                    next_state = ST_RESET_OUT;
                    next_timer = '0;
                end
            end
            ST_RESET_OUT: begin
                next_timer = timer + 1'b1;
                if (timer >= PHASE_TIME_W'(RESET_CYCLES - 1)) begin
                    next_state = ST_NORMAL;
                    next_timer = '0;
                end
            end
            default: begin
                next_state = ST_NORMAL;
                next_timer = '0;
            end
        endcase
        // overcurrent and stop override every phase
        if (overcurrent) begin
            if (run) next_lockout = 1'b1;
            next_state = ST_NORMAL;
            next_timer = '0;
        end else if (stop_lvl) begin
            next_state = ST_NORMAL;
            next_timer = '0;
        end
        case (next_state)
            ST_PRE: next_code = CODE_PRE;
            ST_FAULT: next_code = CODE_FAULT;
            ST_POST: next_code = CODE_POST;
            ST_RESET_IN, ST_RESET_OUT: next_code = CODE_RESET;
            default: next_code = CODE_NORMAL;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_NORMAL;
            timer <= '0;
            hold <= '0;
            lockout <= 1'b0;
            start_prev <= 1'b0;
            ext_prev <= 1'b0;
            state_code_o <= CODE_NORMAL;
        end else begin
            state <= next_state;
            timer <= next_timer;
            hold <= next_hold;
            lockout <= next_lockout;
            start_prev <= start_lvl;
            ext_prev <= ext_lvl;
            state_code_o <= next_code;
        end
    end

    // rated * (1 + 16/10000), computed in wide arithmetic then cut back
    logic [FREQ_W+15:0] freq_wide;
    assign freq_wide = {16'h0000, rated_freq_i} *
                       (FREQ_W + 16)'(FREQ_SCALE_DEN + FREQ_OFFSET_CENTI_PCT);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sim_freq_o <= '0;
        end else begin
            sim_freq_o <= FREQ_W'(freq_wide / (FREQ_W + 16)'(FREQ_SCALE_DEN));
        end
    end

    assign simulation_active_o = run;
    assign protection_disable_o = (state == ST_RESET_IN) || (state == ST_RESET_OUT);
    assign energy_counter_stop_o = run;
    assign voltage_phase_neutral_o = 1'b1;
    // trips pass untouched in normal operation; only a run may suppress them
    assign breaker_trip_o = protection_trip_command_i &
                            (!run || trip_pass_setting_i == TRIP_PASS);
    assign start_refused_o = blocked | lockout;

    a_code_matches_state: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_code_o == ((state == ST_PRE) ? CODE_PRE : (state == ST_FAULT) ? CODE_FAULT :
        (state == ST_POST) ? CODE_POST : (state == ST_NORMAL) ? CODE_NORMAL : CODE_RESET))
        else $error("state code disagrees with phase");
    a_overcurrent_aborts: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        overcurrent |=> state == ST_NORMAL)
        else $error("overcurrent did not abort");
    a_stop_aborts: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        stop_lvl |=> state == ST_NORMAL)
        else $error("stop did not end run");
    a_blocked_no_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state == ST_NORMAL && blocked) |=> state == ST_NORMAL)
        else $error("started while blocked");
    a_lockout_no_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state == ST_NORMAL && lockout) |=> state == ST_NORMAL)
        else $error("started during lockout");
    a_order_pre: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state == ST_PRE && $past(state) != ST_PRE) |-> $past(state) == ST_RESET_IN)
        else $error("pre-fault not entered from reset");
    a_force_post: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state == ST_PRE || state == ST_FAULT) && force_edge && !overcurrent && !stop_lvl)
        |=> state == ST_POST)
        else $error("force did not jump to post-fault");
    a_trip_suppressed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (run && trip_pass_setting_i == TRIP_SUPPRESS) |-> !breaker_trip_o)
        else $error("trip passed while suppressed");
    a_energy_stop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        energy_counter_stop_o == (state_code_o != CODE_NORMAL))
        else $error("energy counters ran during simulation");
    // a reset phase may only be cut short by overcurrent or stop
    a_reset_duration: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state == ST_RESET_IN || state == ST_RESET_OUT) && !overcurrent && !stop_lvl &&
        timer < PHASE_TIME_W'(RESET_CYCLES - 1)) |=> state == $past(state))
        else $error("reset phase ended too early");

    c_full_run: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        state == ST_RESET_OUT ##1 state == ST_NORMAL);
    c_forced_post: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        state == ST_FAULT ##1 state == ST_POST && force_edge);
    c_overcurrent_abort: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        run && overcurrent);
    c_manual_stop: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        run && stop_lvl && !overcurrent);
endmodule : fault_simulation_sequencer

// *** sim/field_side_model.sv ***
// field side of the sequencer: protection trip source and phase current supervision
// assumes the bench raises requests; both answers come one system clock later
`timescale 1ns/1ps
module field_side_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic trip_req_i,
    input wire logic overcurrent_req_i,
    output logic protection_trip_command_o,
    output logic phase_overcurrent_o
);
    // a protection element decides on the next sample, never in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            protection_trip_command_o <= 1'h0;
            phase_overcurrent_o <= 1'h0;
        end else begin
            protection_trip_command_o <= trip_req_i;
            phase_overcurrent_o <= overcurrent_req_i;
        end
    end
endmodule : field_side_model

// *** sim/fault_simulation_sequencer_tb.sv ***
// self-checking bench for the fault simulation sequencer
// assumes short reset and lockout counts set here; inputs change at the falling edge
`timescale 1ns/1ps
module fault_simulation_sequencer_tb;
    import fault_sim_pkg::*;
    localparam int unsigned RST_C = 10;
    localparam longint unsigned HOLD_C = 20;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic man_start = 1'h0, man_stop = 1'h0, ext_start = 1'h0, ext_asg = 1'h1;
    logic blk1 = 1'h0, blk2 = 1'h0, force_post = 1'h0, force_asg = 1'h0;
    logic trip_pass = 1'h0, trip_req = 1'h0, oc_req = 1'h0, trip_cmd, overcurrent;
    logic [2:0] state_code;
    logic prot_dis, energy_stop, vpn, breaker_trip, refused, active;
    logic [FREQ_W-1:0] sim_freq;
    int error_cnt = 0;
    int n_checks = 0;

    field_side_model field (.clock_i(clock_i), .rst_n_i(rst_n_i), .trip_req_i(trip_req),
        .overcurrent_req_i(oc_req), .protection_trip_command_o(trip_cmd),
        .phase_overcurrent_o(overcurrent));

    fault_simulation_sequencer #(.RESET_CYCLES(RST_C), .HOLD_CYCLES(HOLD_C)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .manual_start_i(man_start),
        .manual_stop_i(man_stop), .external_start_input_i(ext_start),
        .external_start_assigned_i(ext_asg), .external_block_one_i(blk1),
        .external_block_two_i(blk2), .force_post_fault_input_i(force_post),
        .force_post_assigned_i(force_asg), .phase_overcurrent_i(overcurrent),
        .trip_pass_setting_i(trip_pass), .protection_trip_command_i(trip_cmd),
        .pre_fault_cycles_i(32'h5), .fault_cycles_i(32'h6), .post_fault_cycles_i(32'h7),
        .rated_freq_i(32'hC350), .state_code_o(state_code), .protection_disable_o(prot_dis),
        .energy_counter_stop_o(energy_stop), .simulation_active_o(active),
        .voltage_phase_neutral_o(vpn), .sim_freq_o(sim_freq),
        .breaker_trip_o(breaker_trip), .start_refused_o(refused));

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for a state code; running out ends the run
    task automatic wait_code(input logic [2:0] code, input int bound);
        for (int i = 0; i < bound; i++) begin
            if (state_code === code) break;
            @(negedge clock_i);
        end
        n_checks++;
        if (state_code !== code) begin
            error_cnt++;
            $display("Error at %0t: state code %0h not reached", $time, code);
            results();
        end
    endtask : wait_code

    // one clean start edge; a single cycle is enough for the synchroniser here
    task automatic pulse(input logic ext);
        if (ext) ext_start = 1'h1;
        else man_start = 1'h1;
        @(negedge clock_i);
        ext_start = 1'h0;
        man_start = 1'h0;
    endtask : pulse

    task automatic phase(input logic [2:0] code, input int len, input logic dis);
        int n;
        n = 0;
        wait_code(code, 40);
        while (state_code === code && n < 200) begin
            check(prot_dis, dis);
            check(energy_stop, 1'h1);
            check(active, 1'h1);
            check(breaker_trip, trip_pass);
            n++;
            @(negedge clock_i);
        end
        check(n, len);
    endtask : phase

    initial begin
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'h1;
        trip_req = 1'h1;
        repeat (2) @(negedge clock_i);
        check(vpn, 1'h1);
        check(active, 1'h0);
        check(sim_freq, 32'hC3A0);
        check(breaker_trip, 1'h1);
        // trips held active throughout: suppressed first, passed second
        for (int p = 0; p < 2; p++) begin
            trip_pass = p[0];
            pulse(1'h0);
            phase(CODE_RESET, RST_C, 1'h1);
            phase(CODE_PRE, 5, 1'h0);
            phase(CODE_FAULT, 6, 1'h0);
            phase(CODE_POST, 7, 1'h0);
            phase(CODE_RESET, RST_C, 1'h1);
            wait_code(CODE_NORMAL, 2);
            check(energy_stop, 1'h0);
            check(active, 1'h0);
            check(breaker_trip, 1'h1);
        end
        force_asg = 1'h1;
        for (int c = 1; c < 3; c++) begin
            pulse(1'h0);
            wait_code(c[2:0], 40);
            force_post = 1'h1;
            repeat (4) @(negedge clock_i);
            check(state_code, CODE_POST);
            force_post = 1'h0;
            wait_code(CODE_NORMAL, 40);
        end
        force_asg = 1'h0;
        // force held high but unassigned must not cut the run short
        force_post = 1'h1;
        pulse(1'h0);
        wait_code(CODE_FAULT, 40);
        man_stop = 1'h1;
        wait_code(CODE_NORMAL, 4);
        check(prot_dis, 1'h0);
        man_stop = 1'h0;
        force_post = 1'h0;
        pulse(1'h0);
        wait_code(CODE_FAULT, 40);
        oc_req = 1'h1;
        wait_code(CODE_NORMAL, 5);
        repeat (2) @(negedge clock_i);
        check(refused, 1'h1);
        oc_req = 1'h0;
        repeat (3) @(negedge clock_i);
        // a start well inside the quiet interval must be ignored
        pulse(1'h0);
        repeat (6) @(negedge clock_i);
        check(state_code, CODE_NORMAL);
        repeat (20) @(negedge clock_i);
        check(refused, 1'h0);
        pulse(1'h0);
        wait_code(CODE_RESET, 4);
        man_stop = 1'h1;
        wait_code(CODE_NORMAL, 4);
        man_stop = 1'h0;
        for (int b = 0; b < 2; b++) begin
            blk1 = (b == 0);
            blk2 = (b == 1);
            repeat (4) @(negedge clock_i);
            check(refused, 1'h1);
            pulse(b[0]);
            repeat (4) @(negedge clock_i);
            check(state_code, CODE_NORMAL);
        end
        blk1 = 1'h0;
        blk2 = 1'h0;
        repeat (4) @(negedge clock_i);
        // an unassigned external start is ignored
        ext_asg = 1'h0;
        pulse(1'h1);
        repeat (4) @(negedge clock_i);
        check(state_code, CODE_NORMAL);
        ext_asg = 1'h1;
        pulse(1'h1);
        wait_code(CODE_RESET, 4);
        results();
    end
endmodule : fault_simulation_sequencer_tb
